//--- rtl/dpc_pkg.sv
package dpc_pkg;
    // ----------------------------------------------------------------
    // slave address
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_UPPER     = 5'h0b; // fixed pattern 01011
    // ----------------------------------------------------------------
    // instruction byte fields, bit positions
    // ----------------------------------------------------------------
    localparam int         INS_SEL_HI     = 6;
    localparam int         INS_SEL_LO     = 5;
    localparam int         INS_MIDRST     = 4;
    localparam int         INS_SHUTDOWN_PIN_N       = 3;
    localparam int         INS_OUT2       = 2;
    localparam int         INS_OUT1       = 1;
    // ----------------------------------------------------------------
    // reset values and sizes
    // ----------------------------------------------------------------
    localparam logic       LOGIC_OUT_RST  = 1'b0;
    localparam logic [7:0] WIPER_MID      = 8'h80;
    localparam int         NUM_CH         = 4;
    localparam logic [3:0] BIT_LAST       = 4'h7;
    localparam logic [3:0] BIT_ACK        = 4'h8;
    localparam logic [3:0] BIT_START      = 4'hf; // start's own scl fall wraps it to 0
endpackage

//--- rtl/dpc_wiper_mem.sv
// small store of the four wiper settings, registered read port
module dpc_wiper_mem
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [1:0] rd_addr,
    output logic      [7:0] rd_data
);

    logic [7:0] mem [dpc_pkg::NUM_CH];

    // ----------------------------------------------------------------
    // storage, one entry per channel
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < dpc_pkg::NUM_CH; g++)
        begin : g_ent
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                    mem[g] <= dpc_pkg::WIPER_MID;
                else if (wr_en && wr_addr == 2'(g))
                    mem[g] <= wr_data;
            end
        end
    endgenerate

    // registered read
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rd_data <= dpc_pkg::WIPER_MID;
        else
            rd_data <= mem[rd_addr];
    end

endmodule

//--- rtl/dpc_ctrl.sv
// Function
// - both logic outputs are low after reset until programmed.
// - logic outputs follow their bits of the instruction byte, frame two.
// - instruction-only write with STOP updates outputs; wipers untouched unless the midscale bit sets the selected one to mid.
// - fresh instruction-only transaction after a STOP also updates outputs.
// - a new START in place of STOP keeps the data write already acked; following instruction-only write works.
// - shutdown from low pin or from instruction shutdown bit.
// - programming still works under pin shutdown; release applies new setting.
// - two low address bits come from the strap pins.
// - instruction byte: x, sel hi, sel lo, midscale, shutdown, out2, out1, x.
// - upper five address bits must match 01011.
// - shutdown bit hits selected channel only; pin hits all four.
// - shutdown keeps stored wiper value; previous setting returns after.
module dpc_ctrl
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       shutdown_pin_n,
    input  wire logic       addr_strap_low,
    input  wire logic       addr_strap_high,
    output logic            logic_out_first,
    output logic            logic_out_second,
    output logic      [3:0] channel_shutdown,
    output logic      [3:0] channel_active_sd,
    output logic      [1:0] sel_channel,
    output logic      [7:0] sel_wiper
);

    // ----------------------------------------------------------------
    // bus state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_INS   = 3'b010,
        ST_DATA  = 3'b011,
        ST_IGN   = 3'b100
    } dpc_state_e;

    dpc_state_e state;
    logic       scl_d;
    logic       sda_d;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic       acking;
    logic [7:0] ins;
    logic [3:0] sd_bits;
    logic       wr_en;
    logic [7:0] wr_data;

    wire logic scl_rise  = scl_in && !scl_d;
    wire logic scl_fall  = !scl_in && scl_d;
    wire logic start_c   = scl_in && scl_d && sda_d && !sda_in;
    wire logic stop_c    = scl_in && scl_d && !sda_d && sda_in;
    wire logic [7:0] byte_in = {shreg[6:0], sda_in};
    wire logic addr_hit  = byte_in[7:3] == dpc_pkg::ADDR_UPPER
                        && byte_in[2:1] == {addr_strap_high, addr_strap_low}
                        && !byte_in[0];

    // line sampling for edge and condition detection
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end
        else
        begin
            scl_d <= scl_in;
            sda_d <= sda_in;
        end
    end

    // ----------------------------------------------------------------
    // frame sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state   <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg   <= 8'h00;
            acking  <= 1'b0;
        end
        else if (start_c)
        begin
            state   <= ST_ADDR;
            bit_cnt <= dpc_pkg::BIT_START; // scl fall closing the start is not a bit
            acking  <= 1'b0;
        end
        else if (stop_c)
        begin
            state  <= ST_IDLE;
            acking <= 1'b0;
        end
        else if (state != ST_IDLE && state != ST_IGN)
        begin
            if (scl_rise && bit_cnt <= dpc_pkg::BIT_LAST)
            begin
                shreg   <= byte_in;
                if (bit_cnt == dpc_pkg::BIT_LAST && state == ST_ADDR && !addr_hit)
                    state <= ST_IGN;
            end
            if (scl_fall)
            begin
                if (bit_cnt == dpc_pkg::BIT_LAST)
                begin
                    acking  <= 1'b1;
                    bit_cnt <= dpc_pkg::BIT_ACK;
                end
                else if (bit_cnt == dpc_pkg::BIT_ACK)
                begin
                    acking  <= 1'b0;
                    bit_cnt <= 4'h0;
                    if (state == ST_ADDR)
                        state <= ST_INS;
                    else if (state == ST_INS)
                        state <= ST_DATA;
                end
                else
                    bit_cnt <= bit_cnt + 4'h1;
            end
        end
    end

    // acknowledge drive, open drain low
    assign sda_out = 1'b0;
    assign sda_oe  = acking;

    // ----------------------------------------------------------------
    // instruction latch and logic outputs
    // ----------------------------------------------------------------
    wire logic ins_done  = acking && scl_fall && bit_cnt == dpc_pkg::BIT_ACK
                        && state == ST_INS;
    wire logic data_done = acking && scl_fall && bit_cnt == dpc_pkg::BIT_ACK
                        && state == ST_DATA;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            logic_out_first  <= dpc_pkg::LOGIC_OUT_RST;
            logic_out_second <= dpc_pkg::LOGIC_OUT_RST;
            ins              <= 8'h00;
        end
        else if (ins_done)
        begin
            ins              <= shreg;
            logic_out_first  <= shreg[dpc_pkg::INS_OUT1];
            logic_out_second <= shreg[dpc_pkg::INS_OUT2];
        end
    end

    // per-channel shutdown bit, selected channel only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sd_bits <= 4'h0;
        else if (ins_done)
            sd_bits[shreg[dpc_pkg::INS_SEL_HI:dpc_pkg::INS_SEL_LO]]
                <= shreg[dpc_pkg::INS_SHUTDOWN_PIN_N];
    end

    // wiper writes: data byte or midscale reset; shutdown never writes
    always_comb
    begin
        wr_en   = 1'b0;
        wr_data = shreg;
        if (ins_done && shreg[dpc_pkg::INS_MIDRST])
        begin
            wr_en   = 1'b1;
            wr_data = dpc_pkg::WIPER_MID;
        end
        else if (data_done)
            wr_en = 1'b1;
    end

    assign sel_channel = ins_done ? shreg[dpc_pkg::INS_SEL_HI:dpc_pkg::INS_SEL_LO]
                                  : ins[dpc_pkg::INS_SEL_HI:dpc_pkg::INS_SEL_LO];

    dpc_wiper_mem u_mem
    (
        .clock   (clock),
        .rst     (rst),
        .wr_en   (wr_en),
        .wr_addr (sel_channel),
        .wr_data (wr_data),
        .rd_addr (sel_channel),
        .rd_data (sel_wiper)
    );

    // effective shutdown per channel, stored wipers kept intact
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            channel_shutdown  <= 4'h0;
            channel_active_sd <= 4'h0;
        end
        else
        begin
            channel_shutdown  <= sd_bits | {4{!shutdown_pin_n}};
            channel_active_sd <= sd_bits;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_out_update;
        @(posedge clock) disable iff (rst)
        ins_done |=> logic_out_first == $past(shreg[1]) && logic_out_second == $past(shreg[2]);
    endproperty
    a_out_update: assert property (p_out_update) else $error("outputs not updated");

    property p_out_hold;
        @(posedge clock) disable iff (rst)
        !ins_done |=> $stable(logic_out_first) && $stable(logic_out_second);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("outputs changed unprompted");

    property p_pin_sd;
        @(posedge clock) disable iff (rst)
        !shutdown_pin_n |=> channel_shutdown == 4'hf;
    endproperty
    a_pin_sd: assert property (p_pin_sd) else $error("pin shutdown missed");

    property p_pin_release;
        @(posedge clock) disable iff (rst)
        shutdown_pin_n |=> channel_shutdown == $past(sd_bits);
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("release wrong");

    property p_ack_match;
        @(posedge clock) disable iff (rst)
        state == ST_ADDR && acking |-> shreg[7:3] == dpc_pkg::ADDR_UPPER
            && shreg[2:1] == {addr_strap_high, addr_strap_low} && !shreg[0];
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("ack from ignored state");

    property p_sd_no_write;
        @(posedge clock) disable iff (rst)
        wr_en |-> data_done
            || (ins_done && shreg[dpc_pkg::INS_MIDRST] && wr_data == dpc_pkg::WIPER_MID);
    endproperty
    a_sd_no_write: assert property (p_sd_no_write) else $error("stray wiper write");

    property p_start_restart;
        @(posedge clock) disable iff (rst)
        start_c |=> state == ST_ADDR && bit_cnt == dpc_pkg::BIT_START;
    endproperty
    a_start_restart: assert property (p_start_restart) else $error("start not taken");

    property p_stop_idle;
        @(posedge clock) disable iff (rst)
        stop_c && !start_c |=> state == ST_IDLE && !acking;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

endmodule

//--- verification/dpc_bus_master.sv
module dpc_bus_master
(
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // bus master model, a released sda is pulled high
    // ----------------------------------------------------------------
    // idle bus at time zero
    initial
    begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end
    // keep a level for four system clocks
    task automatic hold4();
        repeat (4) @(posedge clock);
    endtask
    // start, also a restart in mid cycle
    task automatic start();
        sda_drv <= 1'b1;
        hold4();
        scl     <= 1'b1;
        hold4();
        sda_drv <= 1'b0;
        hold4();
        scl     <= 1'b0;
        hold4();
    endtask
    // stop closes the write cycle
    task automatic stop();
        sda_drv <= 1'b0;
        hold4();
        scl     <= 1'b1;
        hold4();
        sda_drv <= 1'b1;
        hold4();
    endtask
    // one bit, sda moves only while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        hold4();
        scl     <= 1'b1;
        hold4();
        r = sda_line;
        scl     <= 1'b0;
        hold4();
    endtask
    // byte msb first, then the released ack slot
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
endmodule

//--- verification/dpc_ctrl_tb_top.sv
module dpc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clock;
    logic       rst;
    logic       scl;
    logic       m_sda;
    logic       sda_line;
    logic       sda_out;
    logic       sda_oe;
    logic       shutdown_pin_n;
    logic       addr_strap_low;
    logic       addr_strap_high;
    logic       logic_out_first;
    logic       logic_out_second;
    logic [3:0] channel_shutdown;
    logic [3:0] channel_active_sd;
    logic [1:0] sel_channel;
    logic [7:0] sel_wiper;
    logic [7:0] outs;
    logic       ack;
    int         miscompares;
    int         checks_done;
    // ----------------------------------------------------------------
    // open-drain data line with pull-up, clock, instances
    // ----------------------------------------------------------------
    assign sda_line = m_sda & (sda_oe ? sda_out : 1'b1);
    assign outs     = {6'h00, logic_out_second, logic_out_first};
    initial clock = 1'b0;
    always #20 clock = ~clock;
    dpc_ctrl i_dut
    (
        .clock            (clock),
        .rst              (rst),
        .scl_in           (scl),
        .sda_in           (sda_line),
        .sda_out          (sda_out),
        .sda_oe           (sda_oe),
        .shutdown_pin_n   (shutdown_pin_n),
        .addr_strap_low   (addr_strap_low),
        .addr_strap_high  (addr_strap_high),
        .logic_out_first  (logic_out_first),
        .logic_out_second (logic_out_second),
        .channel_shutdown (channel_shutdown),
        .channel_active_sd(channel_active_sd),
        .sel_channel      (sel_channel),
        .sel_wiper        (sel_wiper)
    );
    dpc_bus_master i_master
    (
        .clock   (clock),
        .sda_line(sda_line),
        .scl     (scl),
        .sda_drv (m_sda)
    );
    // compare and count
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    function automatic logic [7:0] ad(input logic [1:0] s);
        return {dpc_pkg::ADDR_UPPER, s, 1'b0};
    endfunction
    function automatic logic [7:0] ib(input logic [1:0] ch, input logic rs, input logic sd,
                                      input logic o2, input logic o1);
        return {1'b0, ch, rs, sd, o2, o1, 1'b0};
    endfunction
    // write: address, instruction, data when dat[8], stop when fin
    task automatic wr(input logic [7:0] adr, input logic [7:0] ins, input logic [8:0] dat,
                      input logic fin);
        logic r;
        i_master.start();
        i_master.put_byte(adr, ack);
        i_master.put_byte(ins, r);
        if (dat[8])
            i_master.put_byte(dat[7:0], r);
        if (fin)
            i_master.stop();
        repeat (2) @(posedge clock);
    endtask
    // watchdog
    initial
    begin
        repeat (40000) @(posedge clock);
        miscompares++;
        report_and_stop();
    end
    // test sequence
    initial
    begin
        miscompares     = 0;
        checks_done     = 0;
        rst             = 1'b1;
        shutdown_pin_n  = 1'b1;
        addr_strap_low  = 1'b0;
        addr_strap_high = 1'b0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk("outs", outs, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            addr_strap_low  <= s[0];
            addr_strap_high <= s[1];
            @(posedge clock);
            wr(ad(s[1:0]), ib(s[1:0], 1'b0, 1'b0, s[1], s[0]), {1'b1, 6'h05, s[1:0]}, 1'b1);
            chk("ack", {7'h00, ack}, 8'h01);
            chk("outs", outs, {6'h00, s[1:0]});
            chk("wiper", sel_wiper, {6'h05, s[1:0]});
            wr(ad(~s[1:0]), ib(s[1:0], 1'b0, 1'b0, ~s[1], ~s[0]), 9'h000, 1'b1);
            chk("ack", {7'h00, ack}, 8'h00);
            chk("outs", outs, {6'h00, s[1:0]});
        end
        for (int k = 0; k < 2; k++)
        begin
            wr(k ? 8'h01 | ad(2'h3) : {dpc_pkg::ADDR_UPPER ^ 5'h10, 3'h6}, 8'h00, 9'h000, 1'b1);
            chk("ack", {7'h00, ack}, 8'h00);
            chk("outs", outs, 8'h03);
        end
        wr(ad(2'h3), ib(2'h1, 1'b0, 1'b0, 1'b1, 1'b0), 9'h000, 1'b1);
        chk("outs", outs, 8'h02);
        chk("chan", {6'h00, sel_channel}, 8'h01);
        chk("wiper", sel_wiper, 8'h15);
        wr(ad(2'h3), ib(2'h2, 1'b0, 1'b0, 1'b0, 1'b0), 9'h1a5, 1'b1);
        wr(ad(2'h3), ib(2'h2, 1'b0, 1'b0, 1'b0, 1'b1), 9'h000, 1'b1);
        chk("outs", outs, 8'h01);
        chk("wiper", sel_wiper, 8'ha5);
        wr(ad(2'h3), ib(2'h3, 1'b0, 1'b0, 1'b0, 1'b0), 9'h13c, 1'b0);
        wr(ad(2'h3), ib(2'h3, 1'b0, 1'b0, 1'b1, 1'b1), 9'h000, 1'b1);
        chk("ack", {7'h00, ack}, 8'h01);
        chk("outs", outs, 8'h03);
        chk("wiper", sel_wiper, 8'h3c);
        wr(ad(2'h3), ib(2'h2, 1'b0, 1'b1, 1'b1, 1'b1), 9'h000, 1'b1);
        chk("shutdown_pin_n", {4'h0, channel_shutdown}, 8'h04);
        chk("sdbits", {4'h0, channel_active_sd}, 8'h04);
        chk("wiper", sel_wiper, 8'ha5);
        shutdown_pin_n <= 1'b0;
        repeat (3) @(posedge clock);
        chk("shutdown_pin_n", {4'h0, channel_shutdown}, 8'h0f);
        wr(ad(2'h3), ib(2'h2, 1'b0, 1'b0, 1'b1, 1'b0), 9'h000, 1'b1);
        chk("ack", {7'h00, ack}, 8'h01);
        chk("outs", outs, 8'h02);
        chk("shutdown_pin_n", {4'h0, channel_shutdown}, 8'h0f);
        shutdown_pin_n <= 1'b1;
        repeat (3) @(posedge clock);
        chk("shutdown_pin_n", {4'h0, channel_shutdown}, 8'h00);
        chk("wiper", sel_wiper, 8'ha5);
        wr(ad(2'h3), ib(2'h1, 1'b1, 1'b0, 1'b1, 1'b0), 9'h000, 1'b1);
        chk("wiper", sel_wiper, dpc_pkg::WIPER_MID);
        report_and_stop();
    end
endmodule
